// *** core/psd_params.svh ***
/*
 * Constants of the synthesizer divider block: register indices, field
 * positions, reset values and division counts.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// ==========================================
// Register indices (byte address is 4 x index)
`define PSD_IDX_SKIP   8'h78
`define PSD_IDX_PROG   8'h79
`define PSD_IDX_STAT   8'h7a

// ==========================================
// Field positions and widths
`define PSD_SKIP_LSB   0
`define PSD_SKIP_W     4
`define PSD_EN_BIT     5
`define PSD_PROG_W     6
`define PSD_ST_LUT_LSB 8

// ==========================================
// Reset values
`define PSD_SKIP_RST   4'h0
`define PSD_EN_RST     1'b0
`define PSD_PROG_RST   6'h00

// ==========================================
// Division counts
`define PSD_XO_MHZ     100
`define PSD_REF_MHZ    20
`define PSD_PRE_A      2'd3
`define PSD_MOD_HI     4'd11
`define PSD_MOD_LO     4'd10
`define PSD_D5_LAST    3'd4
`define PSD_LUT_N      5

// ==========================================
// Bus responses
`define PSD_RESP_OKAY  2'h0
`define PSD_RESP_SLV   2'h2

`endif

// *** core/psd_pkg.sv ***
/*
 * Types shared by the synthesizer divider block.
 * Assumes the parameter header can be included by bare name.
 */
`include "psd_params.svh"
`default_nettype none

package psd_pkg;
	// One-hot selection of the compensation switches
	typedef logic [`PSD_LUT_N-1:0] psd_sel_t;
	// Bus response code
	typedef logic [1:0]            psd_resp_t;
endpackage

`default_nettype wire

// *** core/psd_top.sv ***
/*
 * Reference divider chain, fixed-loop feedback divider, pulse-swallow
 * programmable divider, compensation table, lock status return and an
 * AXI4-Lite register slave, all on one clock.
 * Assumes oscillator and lock signals arrive asynchronously on pins and
 * are slow against clk; the strap input is static.
 */
// Contract
// - Prescaler divides by 11, then 10
// - Skip counter halts at terminal count
// - Divider output reloads skip, restarts cycle
// - Decade skip counter, eight-bit programmable counter
// - Divider output feeds loop comparator
// - Fixed divide by four then two
// - Crystal divided to 20 MHz reference
// - Toggle halves 20 MHz to 10 MHz
// - 10 MHz divided by sixteen
// - Strap bypasses halving, gives 1.25 MHz
// - Fixed loop return divided 2,5,5
// - Table selects one of five settings
// - Programmable lock drives common, own line
// - Fixed lock drives common, own line
// - Status drivers only when enabled
// - Skip latch at 78h, enable bit 5
// - Divider latch at 79h, bits 0-5
// - Table addressed by five load MSBs
`include "psd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module psd_top import psd_pkg::*; #(
	parameter int XO_DIV = `PSD_XO_MHZ / `PSD_REF_MHZ, // Crystal to reference ratio
	parameter int PROG_W = 8,                          // Programmable counter width
	parameter int ADDR_W = 12                          // Bus address width
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Oscillator pins and strap
	input  wire logic              xo_in,
	input  wire logic              fb_prog_in,
	input  wire logic              fb_fixed_in,
	input  wire logic              half_bypass_in,
	// Lock detector pins
	input  wire logic              lock_prog_in,
	input  wire logic              lock_fixed_in,
	// Divided outputs
	output logic                   ref20_o,
	output logic                   ref10_o,
	output logic                   ref_prog_o,
	output logic                   fb_fixed10_o,
	output logic                   fb_prog_o,
	// Compensation switches
	output psd_sel_t               rate_sel_o,
	output psd_sel_t               offs_sel_o,
	// Open-drain status lines, enable low while driving
	output logic                   stat_common_o,
	output logic                   stat_common_oe_n,
	output logic                   stat_prog_o,
	output logic                   stat_prog_oe_n,
	output logic                   stat_fixed_o,
	output logic                   stat_fixed_oe_n
);

	// ==========================================
	// Parameter checks
	// Crystal count register is eight bits wide
	if (PROG_W < `PSD_PROG_W || XO_DIV < 2 || XO_DIV > 256 || ADDR_W < 10) begin : g_chk
		$error("psd_top: parameter out of range");
	end

	// ==========================================
	// Functions
	// Register index of a byte address, all ones when unmapped
	function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		if (a[1:0] != 2'b00 || (a >> 10) != '0 ||
		    (i != `PSD_IDX_SKIP && i != `PSD_IDX_PROG && i != `PSD_IDX_STAT)) begin
			i = 8'hff;
		end
		return i;
	endfunction

	// Compensation setting for the five load MSBs, one-hot
	function automatic psd_sel_t lut(input logic [4:0] a);
		logic [7:0] p;
		p = 8'(a) * 8'd5;
		return psd_sel_t'(1) << p[7:5];
	endfunction

	// ==========================================
	// Input synchronisers
	localparam int NS = 6;
	logic [NS-1:0] raw;      // Pin bundle
	logic [NS-1:0] s1_q;     // First stage, read only by s2_q
	logic [NS-1:0] s2_q;     // Synchronised level
	logic [NS-1:0] s3_q;     // Delayed copy for edge detection
	assign raw = {half_bypass_in, lock_fixed_in, lock_prog_in,
	              fb_fixed_in, fb_prog_in, xo_in};

	// Two-flop synchroniser per pin
	for (genvar g = 0; g < NS; g++) begin : g_sync
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				s1_q[g] <= 1'b0;
				s2_q[g] <= 1'b0;
				s3_q[g] <= 1'b0;
			end else begin
				s1_q[g] <= raw[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
			end
		end
	end

	logic xo_rise, fbp_rise, fbf_rise, lockp, lockf, bypass;
	assign xo_rise  = s2_q[0] & ~s3_q[0];
	assign fbp_rise = s2_q[1] & ~s3_q[1];
	assign fbf_rise = s2_q[2] & ~s3_q[2];
	assign lockp    = s2_q[3];
	assign lockf    = s2_q[4];
	assign bypass   = s2_q[5];

	// ==========================================
	// Registers
	logic [`PSD_SKIP_W-1:0] skip_lat_q;   // Skip load value
	logic                   stat_en_q;    // Status return enable
	logic [`PSD_PROG_W-1:0] prog_lat_q;   // Programmable load value
	logic                   aw_have_q;    // Write address held
	logic                   w_have_q;     // Write data held
	logic [ADDR_W-1:0]      awaddr_q;
	logic [31:0]            wdata_q;
	logic                   wstrb0_q;
	logic                   wr_do;
	logic [7:0]             wr_idx;
	assign wr_do  = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_idx = reg_idx(awaddr_q);

	// Write channel handshakes and response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PSD_RESP_OKAY;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb0_q      <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb0_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == 8'hff) ? `PSD_RESP_SLV : `PSD_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have_q     <= 1'b0;
				w_have_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Load latches, written only on a matching index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			skip_lat_q <= `PSD_SKIP_RST;
			stat_en_q  <= `PSD_EN_RST;
			prog_lat_q <= `PSD_PROG_RST;
		end else if (wr_do && wstrb0_q) begin
			if (wr_idx == `PSD_IDX_SKIP) begin
				skip_lat_q <= wdata_q[`PSD_SKIP_LSB +: `PSD_SKIP_W];
				stat_en_q  <= wdata_q[`PSD_EN_BIT];
			end
			if (wr_idx == `PSD_IDX_PROG) begin
				prog_lat_q <= wdata_q[`PSD_PROG_W-1:0];
			end
		end
	end

	// Read channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `PSD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `PSD_RESP_OKAY;
			case (reg_idx(s_axi_araddr))
				`PSD_IDX_SKIP: begin
					s_axi_rdata <= 32'(skip_lat_q) | (32'(stat_en_q) << `PSD_EN_BIT);
				end
				`PSD_IDX_PROG: begin
					s_axi_rdata <= 32'(prog_lat_q);
				end
				`PSD_IDX_STAT: begin
					s_axi_rdata <= 32'({bypass, lockf, lockp}) |
					               (32'(rate_sel_o) << `PSD_ST_LUT_LSB);
				end
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= `PSD_RESP_SLV;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Reference chain
	logic [7:0] xo_cnt_q;    // Crystal edge count
	logic [3:0] r16_q;       // Divide-by-sixteen count
	logic       tick20;
	logic       rise10;
	logic       ref_ev;
	assign tick20 = xo_rise && xo_cnt_q == 8'(XO_DIV - 1);
	assign rise10 = tick20 && !ref10_o;
	assign ref_ev = bypass ? tick20 : rise10;

	// Crystal divider to 20 MHz, toggle to 10 MHz, then by sixteen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xo_cnt_q   <= '0;
			ref20_o    <= 1'b0;
			ref10_o    <= 1'b0;
			r16_q      <= '0;
			ref_prog_o <= 1'b0;
		end else begin
			if (xo_rise) begin
				xo_cnt_q <= tick20 ? 8'h00 : xo_cnt_q + 8'h01;
				ref20_o  <= tick20;
			end
			if (tick20) begin
				ref10_o <= ~ref10_o;
			end
			if (ref_ev) begin
				r16_q      <= r16_q + 4'h1;
				ref_prog_o <= r16_q[3];
			end
		end
	end

	// ==========================================
	// Fixed loop feedback: by 2, then 5 and 5
	logic       f2_q;
	logic [2:0] c5a_q, c5b_q;
	logic       f2_rise, c5a_wrap;
	assign f2_rise  = fbf_rise && !f2_q;
	assign c5a_wrap = f2_rise && c5a_q == `PSD_D5_LAST;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			f2_q         <= 1'b0;
			c5a_q        <= '0;
			c5b_q        <= '0;
			fb_fixed10_o <= 1'b0;
		end else begin
			if (fbf_rise) begin
				f2_q <= ~f2_q;
			end
			if (f2_rise) begin
				c5a_q <= c5a_wrap ? 3'd0 : c5a_q + 3'd1;
			end
			if (c5a_wrap) begin
				c5b_q        <= (c5b_q == `PSD_D5_LAST) ? 3'd0 : c5b_q + 3'd1;
				fb_fixed10_o <= (c5b_q == `PSD_D5_LAST);
			end
		end
	end

	// ==========================================
	// Programmable loop: fixed by 8, then pulse swallow
	logic [1:0]        p4_q;     // Divide-by-four
	logic              p2_q;     // Divide-by-two
	logic [3:0]        dm_q;     // Dual-modulus count
	logic [3:0]        skip_q;   // Decade skip counter
	logic [PROG_W-1:0] pc_q;     // Programmable counter
	logic              pe, mod_tick, out_tick;
	logic [3:0]        modulus;
	assign pe       = fbp_rise && p4_q == `PSD_PRE_A && !p2_q;
	assign modulus  = (skip_q != 4'h0) ? `PSD_MOD_HI : `PSD_MOD_LO;
	assign mod_tick = pe && dm_q == modulus - 4'h1;
	assign out_tick = mod_tick && pc_q == '0;

	// Prescaling by four then two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p4_q <= '0;
			p2_q <= 1'b0;
		end else if (fbp_rise) begin
			p4_q <= p4_q + 2'd1;
			if (p4_q == `PSD_PRE_A) begin
				p2_q <= ~p2_q;
			end
		end
	end

	// Dual-modulus prescaler
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dm_q <= '0;
		end else if (pe) begin
			dm_q <= mod_tick ? 4'h0 : dm_q + 4'h1;
		end
	end

	// Skip and programmable counters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			skip_q    <= '0;
			pc_q      <= '0;
			fb_prog_o <= 1'b0;
		end else begin
			fb_prog_o <= out_tick;
			if (out_tick) begin
				skip_q <= skip_lat_q;
				pc_q   <= PROG_W'(prog_lat_q);
			end else if (mod_tick) begin
				pc_q <= pc_q - PROG_W'(1);
				if (skip_q != 4'h0) begin
					skip_q <= skip_q - 4'h1;
				end
			end
		end
	end

	// ==========================================
	// Compensation table
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_sel_o <= psd_sel_t'(1);
			offs_sel_o <= psd_sel_t'(1);
		end else begin
			rate_sel_o <= lut(prog_lat_q[`PSD_PROG_W-1 -: 5]);
			offs_sel_o <= lut(prog_lat_q[`PSD_PROG_W-1 -: 5]);
		end
	end

	// ==========================================
	// Lock status return, pulled low when unlocked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_common_o    <= 1'b0;
			stat_prog_o      <= 1'b0;
			stat_fixed_o     <= 1'b0;
			stat_common_oe_n <= 1'b1;
			stat_prog_oe_n   <= 1'b1;
			stat_fixed_oe_n  <= 1'b1;
		end else begin
			stat_common_oe_n <= ~(stat_en_q & (~lockp | ~lockf));
			stat_prog_oe_n   <= ~(stat_en_q & ~lockp);
			stat_fixed_oe_n  <= ~(stat_en_q & ~lockf);
		end
	end

	// ==========================================
	// Assertions
	property p_mod_len;
		@(posedge clk) disable iff (rst)
		mod_tick |-> dm_q == ((skip_q != 4'h0) ? 4'd10 : 4'd9);
	endproperty
	a_mod_len: assert property (p_mod_len) else $error("modulus wrong");

	property p_skip_hold;
		@(posedge clk) disable iff (rst)
		(skip_q == 4'h0 && !out_tick) |=> skip_q == 4'h0;
	endproperty
	a_skip_hold: assert property (p_skip_hold) else $error("skip moved");

	property p_reload;
		@(posedge clk) disable iff (rst)
		out_tick |=> skip_q == $past(skip_lat_q) && fb_prog_o;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");

	property p_half;
		@(posedge clk) disable iff (rst)
		tick20 |=> ref10_o != $past(ref10_o);
	endproperty
	a_half: assert property (p_half) else $error("10 MHz not toggled");

	property p_refsel;
		@(posedge clk) disable iff (rst)
		$changed(r16_q) |-> $past(bypass ? tick20 : rise10);
	endproperty
	a_refsel: assert property (p_refsel) else $error("ref source wrong");

	property p_fix5;
		@(posedge clk) disable iff (rst)
		$changed(c5b_q) |-> $past(c5a_wrap);
	endproperty
	a_fix5: assert property (p_fix5) else $error("fixed chain wrong");

	property p_decode;
		@(posedge clk) disable iff (rst)
		(wr_do && wr_idx != `PSD_IDX_PROG) |=> $stable(prog_lat_q);
	endproperty
	a_decode: assert property (p_decode) else $error("latch mis-decoded");

	property p_stat_off;
		@(posedge clk) disable iff (rst)
		!stat_en_q [*2] |-> stat_common_oe_n && stat_prog_oe_n && stat_fixed_oe_n;
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("status driven");

	property p_lock_drv;
		@(posedge clk) disable iff (rst)
		(stat_en_q && !lockf) |=> !stat_common_oe_n && !stat_fixed_oe_n;
	endproperty
	a_lock_drv: assert property (p_lock_drv) else $error("lock not driven");

	property p_lut;
		@(posedge clk) disable iff (rst)
		$onehot(rate_sel_o) && rate_sel_o == offs_sel_o;
	endproperty
	a_lut: assert property (p_lut) else $error("table output bad");

	c_out: cover property (@(posedge clk) disable iff (rst) out_tick);
	c_wr: cover property (@(posedge clk) disable iff (rst) wr_do && wr_idx == `PSD_IDX_SKIP);
	c_rd: cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rready);
	c_byp: cover property (@(posedge clk) disable iff (rst) bypass && tick20);

endmodule

`default_nettype wire

// *** tb/psd_far_model.sv ***
/*
 * Far-side model: oscillator feedback sources, lock detectors and the
 * pulled-up backplane status lines.
 * Assumes the bench clock; the bench sets the lock levels.
 */
`timescale 1ns/100ps
`default_nettype none

module psd_far_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Lock levels wanted by the bench
	input  wire logic       lp_set,
	input  wire logic       lf_set,
	// Status drivers of the block: common, prog, fixed
	input  wire logic [2:0] st_o,
	input  wire logic [2:0] st_oe_n,
	// Sources towards the block
	output logic            xo,
	output logic            fbp,
	output logic            fbf,
	output logic            lock_p,
	output logic            lock_f,
	// Resolved backplane lines
	output logic [2:0]      line
);
	// ==========================================
	// Oscillators
	logic       ph_q; // Half-rate phase
	logic [1:0] cf_q; // Fixed-loop half period count

	// Free-running squares, edges well below clk/3
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_q <= 1'b0;
			cf_q <= 2'h0;
			xo   <= 1'b0;
			fbp  <= 1'b0;
			fbf  <= 1'b0;
		end else begin
			ph_q <= ~ph_q;
			// Crystal and loop feedback on opposite phases
			if (ph_q) xo <= ~xo;
			if (!ph_q) fbp <= ~fbp;
			// Fixed return toggles every third cycle
			cf_q <= (cf_q == 2'h2) ? 2'h0 : cf_q + 2'h1;
			if (cf_q == 2'h2) fbf <= ~fbf;
		end
	end

	// ==========================================
	// Lock detectors follow the bench one cycle late
	always_ff @(posedge clk) begin
		lock_p <= lp_set;
		lock_f <= lf_set;
	end

	// Pull-up wins unless a driver is enabled
	assign line = (st_oe_n & 3'h7) | (~st_oe_n & st_o);
endmodule
`default_nettype wire

// *** tb/tb_pulse_swallow_synth_divider.sv ***
/*
 * Self-checking bench: register access over AXI4-Lite, divider ratios,
 * compensation table and status lines.
 * Assumes the design files and the far-side model are compiled first.
 */
`include "psd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_pulse_swallow_synth_divider import psd_pkg::*; ();
	// ==========================================
	// Addresses and constants
	localparam logic [11:0] A_SKIP = 12'(`PSD_IDX_SKIP) << 2;
	localparam logic [11:0] A_PROG = 12'(`PSD_IDX_PROG) << 2;
	localparam logic [11:0] A_STAT = 12'(`PSD_IDX_STAT) << 2;
	localparam logic [11:0] A_BAD  = 12'h1ec; // Unmapped
	localparam logic [1:0]  OK     = `PSD_RESP_OKAY;
	localparam logic [1:0]  SLV    = `PSD_RESP_SLV;
	localparam int          XD     = 5; // Crystal edges per reference

	// Bus and pins
	logic        clk, rst, strap, lp_set, lf_set;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        xo, fbp, fbf, lock_p, lock_f;
	logic        ref20_o, ref10_o, ref_prog_o, fb_fixed10_o, fb_prog_o;
	psd_sel_t    rate_sel, offs_sel;
	logic [2:0]  st_o, st_oe_n, line;
	// Edge monitors
	logic [4:0]  o_now, o_prev;
	logic        xp, fpp, ffp;
	int          cxo, cprog, cfix, cnt20, err_count, n_tests, q;
	logic [5:0]  last_l;
	// Wanted outputs in MHz; each keeps skip within the reload count, and
	// the last is a low-band setting already raised by the 5 MHz shift
	int          fq[3] = '{50, 220, 155 + 5};

	psd_top #(.XO_DIV(XD)) i_dut (
		.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.xo_in(xo), .fb_prog_in(fbp), .fb_fixed_in(fbf), .half_bypass_in(strap),
		.lock_prog_in(lock_p), .lock_fixed_in(lock_f),
		.ref20_o(ref20_o), .ref10_o(ref10_o), .ref_prog_o(ref_prog_o),
		.fb_fixed10_o(fb_fixed10_o), .fb_prog_o(fb_prog_o),
		.rate_sel_o(rate_sel), .offs_sel_o(offs_sel),
		.stat_common_o(st_o[0]), .stat_common_oe_n(st_oe_n[0]),
		.stat_prog_o(st_o[1]), .stat_prog_oe_n(st_oe_n[1]),
		.stat_fixed_o(st_o[2]), .stat_fixed_oe_n(st_oe_n[2])
	);

	psd_far_model i_far (
		.clk(clk), .rst(rst), .lp_set(lp_set), .lf_set(lf_set),
		.st_o(st_o), .st_oe_n(st_oe_n), .xo(xo), .fbp(fbp), .fbf(fbf),
		.lock_p(lock_p), .lock_f(lock_f), .line(line)
	);

	// ==========================================
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Count source edges and remember output levels
	assign o_now = {ref20_o, fb_prog_o, fb_fixed10_o, ref_prog_o, ref10_o};
	always @(posedge clk) begin
		o_prev <= o_now;
		xp     <= xo;
		fpp    <= fbp;
		ffp    <= fbf;
		if (xo && !xp) cxo <= cxo + 1;
		if (fbp && !fpp) cprog <= cprog + 1;
		if (fbf && !ffp) cfix <= cfix + 1;
		// Count reference events, not the cycles that the level stands high
		if (ref20_o && o_prev[4] === 1'b0) cnt20 <= cnt20 + 1;
	end

	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("comparisons=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// One write: address and data offered together, released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		int k;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				chk(32'(bresp), 32'(er));
				break;
			end
		end
		// No answer counts as a mismatch
		if (k == 50) err_count++;
	endtask

	// One read with expected data and response
	task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				chk(rdata, ed);
				chk(32'(rresp), 32'(er));
				break;
			end
		end
		// No answer counts as a mismatch
		if (k == 50) err_count++;
	endtask

	// Source edge count behind each monitored output
	function automatic int srcv(input int s);
		case (s)
			4: return cxo;
			3: return cprog;
			2: return cfix;
			default: return cnt20;
		endcase
	endfunction

	task automatic rise(input int s);
		int k;
		for (k = 0; k < 25000; k++) begin
			@(posedge clk);
			if (o_now[s] === 1'b1 && o_prev[s] === 1'b0) break;
		end
		// A missing edge counts as a mismatch
		if (k == 25000) err_count++;
	endtask

	// Settle one period, then count source edges over the next one
	task automatic pchk(input int s, input int e);
		int a;
		rise(s);
		rise(s);
		a = srcv(s);
		rise(s);
		chk(32'(srcv(s) - a), 32'(e));
	endtask

	// One-hot compensation setting for a divider load
	function automatic logic [4:0] sel_exp(input logic [5:0] l);
		return 5'h1 << ((l[5:1] * 5) >> 5);
	endfunction

	// ==========================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		finish_test();
	end

	// ==========================================
	// Main sequence
	initial begin
		{rst, strap, lp_set, lf_set} = 4'hb;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{cxo, cprog, cfix, cnt20, err_count, n_tests} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values and unmapped access
		axr(A_SKIP, 32'h0, OK);
		axr(A_PROG, 32'h0, OK);
		axr(A_BAD, 32'h0, SLV);
		// Field widths, strobe gating and decode
		axw(A_SKIP, 32'h29, 4'hf, OK);
		axr(A_SKIP, 32'h29, OK);
		axw(A_PROG, 32'hffffffff, 4'hf, OK);
		axr(A_PROG, 32'h3f, OK);
		axw(A_SKIP, 32'h03, 4'he, OK);
		axw(A_BAD, 32'h00, 4'hf, SLV);
		axr(A_SKIP, 32'h29, OK);
		axr(A_PROG, 32'h3f, OK);
		// Reference chain and fixed loop ratios
		pchk(4, XD);
		pchk(0, 2);
		pchk(1, 32);
		strap <= 1'b1;
		pchk(1, 16);
		strap <= 1'b0;
		pchk(2, 50);
		// Load values formed from the wanted frequency in 5 MHz steps
		for (int k = 0; k < 3; k++) begin
			q = fq[k] / 5;
			axw(A_SKIP, 32'(q % 10), 4'hf, OK);
			axw(A_PROG, 32'(q / 10 - 1), 4'hf, OK);
			pchk(3, 8 * q);
		end
		// Every load through the compensation table
		for (int l = 0; l < 64; l++) begin
			axw(A_PROG, 32'(l), 4'hf, OK);
			repeat (4) @(posedge clk);
			chk(32'({rate_sel, offs_sel}), 32'({sel_exp(6'(l)), sel_exp(6'(l))}));
		end
		last_l = 6'h3f;
		// Lock combinations with the status return on and off
		for (int i = 0; i < 8; i++) begin
			lp_set <= i[0];
			lf_set <= i[1];
			axw(A_SKIP, {26'h0, i[2], 5'h0}, 4'hf, OK);
			repeat (8) @(posedge clk);
			chk(32'(line), i[2] ? 32'({i[1], i[0], i[0] & i[1]}) : 32'h7);
			axr(A_STAT, {19'h0, sel_exp(last_l), 5'h0, strap, i[1], i[0]}, OK);
		end
		finish_test();
	end
endmodule
`default_nettype wire
